// file: rtl/mem_map_map.vh
// Register offsets, field positions, reset values and fixed page numbers of the memory map controller
`ifndef MEM_MAP_MAP_VH
`define MEM_MAP_MAP_VH
// ==========================================
// Register indices (byte address = index * 4)
`define IDX_OPERATING_MODE 8'h0b
`define IDX_DIRECT_PAGE 8'h11
`define IDX_NVM_MAP_CONTROL 8'h13
`define IDX_PROGRAM_PAGE 8'h15
// ==========================================
// Field positions
`define MODE_SELECT_POS 7
`define NVM_RES_POS 0
// ==========================================
// Reset values
`define DIRECT_PAGE_RST 8'h00
`define NVM_MAP_RST 1'b0
`define PROGRAM_PAGE_RST 4'he
// ==========================================
// Fixed page numbers
`define PAGE_FIXED_LOW 4'hc
`define PAGE_FIXED_MID 4'hd
`define PAGE_FIXED_TOP 4'hf
// ==========================================
// Local window bounds (top two local address bits)
`define WIN_FIXED_LOW 2'b00
`define WIN_FIXED_MID 2'b01
`define WIN_PAGED 2'b10
`endif

// file: rtl/memory_map_mode_control.v
// Memory map controller: mode, direct page, NVM mapping and program page registers
//
// Summary of operation
// - Mode bit 7 readable; writes only permitted transitions
// - Mode pin governs in reset, latched at release
// - Illegal transition ignored, locks bit outside special
// - Secured device ignores all mode register writes
// - Direct page resets zero; once in normal
// - Direct page forms local address bits 15:8
// - NVM bit selects flash or NVM at 0x04000
// - Page index selects 16 KB page in window
// - Program page via bus and call/return path
// - Call/return page write completes within instruction
// - Local 0x0000-0x3FFF maps to page 0xC
// - Local 0x4000-0x7FFF maps to page 0xD
// - Local 0xC000-0xFFFF maps to page 0xF
// - Program page resets to 0xE
// - Normal single chip: application, no external bus
// - Special single chip: debug logic controls execution
`timescale 1ns/1ps
`include "mem_map_map.vh"
`default_nettype none
module memory_map_mode_control #(
   parameter ADDR_W = 12
) (
   input wire mclk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire mode_pin,
   input wire secured,
   input wire cpu_page_we,
   input wire [3:0] cpu_page_wdata,
   output wire [3:0] cpu_page_rdata,
   input wire [15:0] local_addr,
   input wire direct_access,
   output reg [15:0] eff_local_addr,
   output reg [17:0] global_addr,
   output wire nvm_resource_sel,
   output wire normal_single_chip,
   output wire background_debug_active,
   output wire external_bus_en
);

   // ==========================================
   // Mode pin synchroniser
   reg mode_pin_s1_q;
   reg mode_pin_s2_q;
   always @(posedge mclk) begin
      mode_pin_s1_q <= mode_pin;
      mode_pin_s2_q <= mode_pin_s1_q;
   end

   // ==========================================
   // Local constants
   localparam [1:0] MODE_HOLD = 2'b00;
   localparam [1:0] MODE_SPECIAL = 2'b01;
   localparam [1:0] MODE_NORMAL = 2'b10;
   localparam [1:0] MODE_LOCKED = 2'b11;

   localparam [2:0] SEL_NONE = 3'b000;
   localparam [2:0] SEL_MODE = 3'b001;
   localparam [2:0] SEL_DIRECT = 3'b010;
   localparam [2:0] SEL_NVM = 3'b011;
   localparam [2:0] SEL_PAGE = 3'b100;

   // ==========================================
   // Register storage and next values
   // Next values are formed in the combinational blocks below
   reg [1:0] mode_state_q;
   reg [1:0] mode_state_d;
   reg [7:0] direct_page_q;
   reg [7:0] direct_page_d;
   reg direct_written_q;
   reg direct_written_d;
   reg nvm_resource_map_bit_q;
   reg nvm_resource_map_bit_d;
   reg [3:0] page_index_bits_q;
   reg [3:0] page_index_bits_d;
   reg [31:0] read_word_d;
   reg [15:0] eff_addr_d;
   reg [17:0] global_addr_d;
   reg [3:0] page_number;
   reg [2:0] reg_sel;

   // ==========================================
   // Bus decode
   wire bus_access;
   wire bus_write;
   wire bus_setup_read;
   wire [7:0] word_index;
   wire index_high_zero;

   assign bus_access = psel & penable;
   assign bus_write = bus_access & pwrite;
   assign bus_setup_read = psel & ~penable & ~pwrite;
   assign word_index = paddr[9:2];
   assign index_high_zero = ~|paddr[ADDR_W-1:10];

   always @* begin
      reg_sel = SEL_NONE;
      if (!index_high_zero) begin
         reg_sel = SEL_NONE;
      end else if (word_index == `IDX_OPERATING_MODE) begin
         reg_sel = SEL_MODE;
      end else if (word_index == `IDX_DIRECT_PAGE) begin
         reg_sel = SEL_DIRECT;
      end else if (word_index == `IDX_NVM_MAP_CONTROL) begin
         reg_sel = SEL_NVM;
      end else if (word_index == `IDX_PROGRAM_PAGE) begin
         reg_sel = SEL_PAGE;
      end else begin
         reg_sel = SEL_NONE;
      end
   end

   // Zero wait states; unmapped words answer with an error
   assign pready = 1'b1;
   assign pslverr = bus_access & (reg_sel == SEL_NONE);

   // ==========================================
   // Write data fields; bits outside them are dropped
   wire wr_mode_bit;
   wire [7:0] wr_direct_page;
   wire wr_nvm_bit;
   wire [3:0] wr_page_index;

   assign wr_mode_bit = pwdata[`MODE_SELECT_POS];
   assign wr_direct_page = pwdata[7:0];
   assign wr_nvm_bit = pwdata[`NVM_RES_POS];
   assign wr_page_index = pwdata[3:0];

   // ==========================================
   // Register write strobes
   wire mode_write;
   wire direct_write;
   wire nvm_write;
   wire page_write;

   assign direct_write = bus_write & (reg_sel == SEL_DIRECT);
   assign nvm_write = bus_write & (reg_sel == SEL_NVM);
   assign page_write = bus_write & (reg_sel == SEL_PAGE);
   // Secured parts never see a mode write at all
   assign mode_write = bus_write & (reg_sel == SEL_MODE) & ~secured;

   // ==========================================
   // Operating mode
   wire mode_held;
   wire mode_from_state;
   wire mode_select_bit;
   wire special;

   // The synchronised pin stands for the mode until the hold state is left
   assign mode_held = (mode_state_q == MODE_HOLD);
   assign mode_from_state = (mode_state_q != MODE_SPECIAL);
   assign mode_select_bit = mode_held ? mode_pin_s2_q : mode_from_state;
   assign special = ~mode_select_bit;

   // ==========================================
   // Permitted mode transitions while unsecured
   reg transition_ok;
   reg transition_locks;

   always @* begin
      transition_ok = 1'b0;
      transition_locks = 1'b0;
      case ({mode_select_bit, wr_mode_bit})
         2'b00: begin
            transition_ok = 1'b1;
         end
         2'b01: begin
            transition_ok = 1'b1;
         end
         2'b11: begin
            transition_ok = 1'b1;
         end
         default: begin
            transition_locks = 1'b1;
         end
      endcase
   end

   always @* begin
      mode_state_d = mode_state_q;
      case (mode_state_q)
         MODE_HOLD: begin
            // First edge after release takes the synchronised pin
            if (mode_pin_s2_q) begin
               mode_state_d = MODE_NORMAL;
            end else begin
               mode_state_d = MODE_SPECIAL;
            end
         end
         MODE_SPECIAL: begin
            // Special may move to normal or stay; nothing is refused
            if (mode_write && transition_ok && wr_mode_bit) begin
               mode_state_d = MODE_NORMAL;
            end
         end
         MODE_NORMAL: begin
            // Asking for special is refused and locks the bit
            if (mode_write && transition_locks) begin
               mode_state_d = MODE_LOCKED;
            end
         end
         MODE_LOCKED: begin
            // Locked until the next reset
            mode_state_d = MODE_LOCKED;
         end
         default: begin
            mode_state_d = MODE_HOLD;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (reset) begin
         mode_state_q <= MODE_HOLD;
      end else begin
         mode_state_q <= mode_state_d;
      end
   end

   // ==========================================
   // Direct page: free in special mode, first write only in normal mode
   always @* begin
      direct_page_d = direct_page_q;
      direct_written_d = direct_written_q;
      if (direct_write) begin
         if (special || !direct_written_q) begin
            direct_page_d = wr_direct_page;
         end
         direct_written_d = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         direct_page_q <= `DIRECT_PAGE_RST;
         direct_written_q <= 1'b0;
      end else begin
         direct_page_q <= direct_page_d;
         direct_written_q <= direct_written_d;
      end
   end

   // ==========================================
   // NVM resource mapping bit
   // Bus writes only; the bit has no other writer
   always @* begin
      nvm_resource_map_bit_d = nvm_resource_map_bit_q;
      if (nvm_write) begin
         nvm_resource_map_bit_d = wr_nvm_bit;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         nvm_resource_map_bit_q <= `NVM_MAP_RST;
      end else begin
         nvm_resource_map_bit_q <= nvm_resource_map_bit_d;
      end
   end

   // ==========================================
   // Program page index
   // The call/return path wins over a bus write and lands on the next edge
   always @* begin
      page_index_bits_d = page_index_bits_q;
      if (cpu_page_we) begin
         page_index_bits_d = cpu_page_wdata;
      end else if (page_write) begin
         page_index_bits_d = wr_page_index;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         page_index_bits_q <= `PROGRAM_PAGE_RST;
      end else begin
         page_index_bits_q <= page_index_bits_d;
      end
   end

   assign cpu_page_rdata = page_index_bits_q;

   // ==========================================
   // Read data, captured in the setup cycle and held for the access phase
   always @* begin
      read_word_d = 32'h00000000;
      case (reg_sel)
         SEL_MODE: begin
            read_word_d[`MODE_SELECT_POS] = mode_select_bit;
         end
         SEL_DIRECT: begin
            read_word_d[7:0] = direct_page_q;
         end
         SEL_NVM: begin
            read_word_d[`NVM_RES_POS] = nvm_resource_map_bit_q;
         end
         SEL_PAGE: begin
            read_word_d[3:0] = page_index_bits_q;
         end
         default: begin
            read_word_d = 32'h00000000;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (bus_setup_read) begin
         prdata <= read_word_d;
      end
   end

   // ==========================================
   // Address translation
   // Direct accesses take the page bits as local bits 15:8 before the window is chosen
   always @* begin
      if (direct_access) begin
         eff_addr_d = {direct_page_q, local_addr[7:0]};
      end else begin
         eff_addr_d = local_addr;
      end
   end

   always @* begin
      case (eff_addr_d[15:14])
         `WIN_FIXED_LOW: begin
            page_number = `PAGE_FIXED_LOW;
         end
         `WIN_FIXED_MID: begin
            page_number = `PAGE_FIXED_MID;
         end
         `WIN_PAGED: begin
            page_number = page_index_bits_q;
         end
         default: begin
            page_number = `PAGE_FIXED_TOP;
         end
      endcase
      global_addr_d = {page_number, eff_addr_d[13:0]};
   end

   // Registered so both addresses change together one cycle after the request
   always @(posedge mclk) begin
      if (reset) begin
         eff_local_addr <= 16'h0000;
         global_addr <= 18'h00000;
      end else begin
         eff_local_addr <= eff_addr_d;
         global_addr <= global_addr_d;
      end
   end

   // ==========================================
   // Mode outputs
   assign nvm_resource_sel = nvm_resource_map_bit_q;
   assign normal_single_chip = mode_select_bit;
   assign background_debug_active = special;
   // Single chip modes only: the external bus never comes up
   assign external_bus_en = 1'b0;

endmodule
`default_nettype wire

// file: bench/mmc_properties.sv
// Port checks of the memory map controller
`timescale 1ns/1ps
`default_nettype none
module mmc_props (
   input wire logic mclk, reset, secured, direct_access, cpu_page_we,
   input wire logic normal_single_chip, background_debug_active, external_bus_en,
   input wire logic [3:0] cpu_page_wdata, cpu_page_rdata,
   input wire logic [15:0] local_addr,
   input wire logic [17:0] global_addr
);
logic [13:0] low_q;
always @(posedge mclk) low_q <= local_addr[13:0];
default clocking @(posedge mclk); endclocking
default disable iff (reset);
chk_call_page: assert property (cpu_page_we |=> cpu_page_rdata == $past(cpu_page_wdata))
   else $error("call path page write lost");
chk_page_reset: assert property ($fell(reset) |-> cpu_page_rdata == 4'he)
   else $error("page reset value wrong");
chk_fixed_low: assert property (!direct_access && local_addr[15:14] == 2'b00
   |=> global_addr[17:14] == 4'hc) else $error("low page wrong");
chk_fixed_mid: assert property (!direct_access && local_addr[15:14] == 2'b01
   |=> global_addr[17:14] == 4'hd) else $error("mid page wrong");
chk_fixed_top: assert property (!direct_access && local_addr[15:14] == 2'b11
   |=> global_addr[17:14] == 4'hf) else $error("top page wrong");
chk_window_page: assert property (!direct_access && local_addr[15:14] == 2'b10
   |=> global_addr == {$past(cpu_page_rdata), low_q}) else $error("window address wrong");
chk_mode_keep: assert property (normal_single_chip |=> normal_single_chip)
   else $error("left normal mode");
chk_secured_mode: assert property (secured |=> $stable(normal_single_chip))
   else $error("mode changed while secured");
chk_no_ext_bus: assert property (!external_bus_en)
   else $error("external bus enabled");
chk_debug_mode: assert property (background_debug_active != normal_single_chip)
   else $error("debug flag wrong");
endmodule
bind memory_map_mode_control mmc_props chk (.*);
`default_nettype wire

// file: bench/cpu_model.sv
// Processor core model: call page path and translation requests
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input wire logic mclk,
   output logic we,
   output logic [3:0] wd,
   output logic [15:0] la,
   output logic da
);
initial begin
   we = 0; wd = 0; la = 0; da = 0;
end
task call_page(input logic [3:0] p);
   @(posedge mclk); we <= 1; wd <= p;
   @(posedge mclk); we <= 0;
endtask
task xlate(input logic [15:0] a, input logic d);
   @(posedge mclk); la <= a; da <= d;
   repeat (2) @(negedge mclk);
endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench of the memory map controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, mode_pin = 0, secured = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, rd;
logic err_rsp = 0;
wire logic pready, pslverr, we, da, nvs;
wire logic [3:0] wd, prd;
wire logic [15:0] la, el;
wire logic [17:0] ga;
wire logic [31:0] prdata;
int err_count = 0, tests_run = 0;
cpu_model cpu (.mclk(mclk), .we(we), .wd(wd), .la(la), .da(da));
memory_map_mode_control uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .mode_pin(mode_pin), .secured(secured), .cpu_page_we(we),
   .cpu_page_wdata(wd), .cpu_page_rdata(prd), .local_addr(la), .direct_access(da),
   .eff_local_addr(el), .global_addr(ga), .nvm_resource_sel(nvs), .normal_single_chip(),
   .background_debug_active(), .external_bus_en());
initial forever #25 mclk = ~mclk;
task chk(input logic [31:0] g, e);
   tests_run++;
   if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
   end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   @(posedge mclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
   @(posedge mclk); penable <= 1;
   do @(posedge mclk); while (pready !== 1'b1);
   rd = prdata; err_rsp = pslverr; psel <= 0; penable <= 0;
endtask
task rdc(input logic [11:0] a, input logic [31:0] e);
   apb(0, a, 0); chk(rd, e);
endtask
task rst(input logic p);
   mode_pin <= p; reset <= 1;
   repeat (16) @(posedge mclk);
   reset <= 0;
   repeat (2) @(posedge mclk);
endtask
task t_special;
   rst(0);
   rdc(12'h054, 32'he); rdc(12'h02c, 0);
   apb(1, 12'h044, 32'h11); apb(1, 12'h044, 32'h12); rdc(12'h044, 32'h12);
   apb(1, 12'h04c, 32'hff); rdc(12'h04c, 1);
   chk(nvs, 1); chk(err_rsp, 0);
   apb(1, 12'h04c, 32'h0); rdc(12'h04c, 0); chk(nvs, 0);
   apb(1, 12'h054, 32'hf7); rdc(12'h054, 32'h7);
   cpu.xlate(16'h9abc, 0); chk(ga, {4'h7, 14'h1abc});
   cpu.xlate(16'h0034, 1); chk(el, 16'h1234);
   chk(ga, 18'h31234);
   cpu.call_page(4'h3); rdc(12'h054, 3);
   rdc(12'h030, 0); chk(err_rsp, 1);
   apb(1, 12'h02c, 32'h80); rdc(12'h02c, 32'h80);
   $display("special mode test done");
endtask
task t_normal;
   rst(1);
   rdc(12'h02c, 32'h80); rdc(12'h044, 0);
   apb(1, 12'h044, 32'h04); apb(1, 12'h044, 32'h55); rdc(12'h044, 32'h04);
   apb(1, 12'h02c, 0); rdc(12'h02c, 32'h80);
   rst(0);
   secured <= 1;
   apb(1, 12'h02c, 32'h80); rdc(12'h02c, 0);
   $display("normal and secured test done");
endtask
task close_out;
   $display("comparisons %0d mismatches %0d", tests_run, err_count);
   if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
endtask
initial begin
   t_special; t_normal; close_out;
end
initial begin
   #2000000; err_count++; close_out;
end
endmodule
`default_nettype wire
